// *** rtl/vcatr_defs.vh ***
// register offsets, field positions, reset values and timing counts
// of the oscillator calibration and converter timing register bank.
// assumes inclusion by bare name from rtl/ files.
`ifndef VCATR_DEFS_VH
`define VCATR_DEFS_VH

// ------------------------------------------------------------------
// serial frame layout
// ------------------------------------------------------------------
`define VCATR_ADDR_W          15
`define VCATR_FRAME_BITS      5'h18
`define VCATR_ADDR_LAST_BIT   5'h0F
`define VCATR_DATA_LAST_BIT   5'h17

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define VCATR_OFS_DECISION    15'h0037
`define VCATR_OFS_DAC_LO      15'h0038
`define VCATR_OFS_DAC_HI      15'h0039
`define VCATR_OFS_LVL_LO      15'h003A
`define VCATR_OFS_LVL_HI      15'h003B
`define VCATR_OFS_CONV_DIV    15'h003E
`define VCATR_OFS_CONV_CTRL   15'h003F
`define VCATR_OFS_MUTE        15'h0040
`define VCATR_OFS_CONV_START  15'h0054
`define VCATR_OFS_STATUS      15'h0058

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define VCATR_DBUF_BIT        7
`define VCATR_CONV_EN_BIT     7
`define VCATR_CONV_PWR_BIT    1
`define VCATR_AUTO_CONV_BIT   0
`define VCATR_START_BIT       0
`define VCATR_ST_CONV_BIT     2
`define VCATR_ST_CAL_BIT      1
`define VCATR_MUTE2_HI        5
`define VCATR_MUTE2_LO        3
`define VCATR_MUTE1_HI        2
`define VCATR_MUTE1_LO        0

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define VCATR_RST_REG         8'h00

// ------------------------------------------------------------------
// timing counts
// ------------------------------------------------------------------
`define VCATR_DECISION_SHIFT  4
`define VCATR_CONV_DIV_SHIFT  2
`define VCATR_CONV_DIV_ADD    15'h0002
`define VCATR_NUM_DECISIONS   3'h7
`define VCATR_CONV_CYCLES     5'h10

`endif

// *** rtl/vcatr_spi.v ***
// serial register port: 24-bit frames, read flag, 15-bit address, data.
// assumes sclk well below ref_clk / 8; all pins are resynchronised.
`timescale 1ns/1ns
`include "vcatr_defs.vh"
module vcatr_spi (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        spi_sclk,
  input  wire        spi_csb_n,
  input  wire        spi_sdi,
  output reg         spi_sdo,
  output reg         spi_sdo_oe_n,
  input  wire [7:0]  rd_data,
  output reg  [14:0] reg_addr,
  output reg  [7:0]  wr_data,
  output reg         wr_strobe
);

  reg        sclk_s1;
  reg        sclk_s2;
  reg        sclk_s3;
  reg        csb_s1;
  reg        csb_s2;
  reg        sdi_s1;
  reg        sdi_s2;
  reg [4:0]  bit_cnt;
  reg [14:0] shift_in;
  reg [7:0]  shift_out;
  reg        is_read;
  reg        load_pending;
  wire       sclk_rise;
  wire       sclk_fall;

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      csb_s1  <= 1'b1;
      csb_s2  <= 1'b1;
      sdi_s1  <= 1'b0;
      sdi_s2  <= 1'b0;
    end else begin
      sclk_s1 <= spi_sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      csb_s1  <= spi_csb_n;
      csb_s2  <= csb_s1;
      sdi_s1  <= spi_sdi;
      sdi_s2  <= sdi_s1;
    end
  end

  assign sclk_rise = sclk_s2 & ~sclk_s3;
  assign sclk_fall = ~sclk_s2 & sclk_s3;

  // ------------------------------------------------------------------
  // frame engine
  // ------------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt      <= 5'h00;
      shift_in     <= 15'h0000;
      shift_out    <= 8'h00;
      is_read      <= 1'b0;
      load_pending <= 1'b0;
      reg_addr     <= 15'h0000;
      wr_data      <= 8'h00;
      wr_strobe    <= 1'b0;
      spi_sdo      <= 1'b0;
      spi_sdo_oe_n <= 1'b1;
    end else begin
      wr_strobe    <= 1'b0;
      load_pending <= 1'b0;
      if (csb_s2) begin
        bit_cnt      <= 5'h00;
        is_read      <= 1'b0;
        spi_sdo      <= 1'b0;
        spi_sdo_oe_n <= 1'b1;
      end else begin
        if (sclk_rise && (bit_cnt != `VCATR_FRAME_BITS)) begin
          shift_in <= {shift_in[13:0], sdi_s2};
          bit_cnt  <= bit_cnt + 5'h01;
          if (bit_cnt == 5'h00) begin
            is_read <= sdi_s2;
          end
          if (bit_cnt == `VCATR_ADDR_LAST_BIT) begin
            reg_addr     <= {shift_in[13:0], sdi_s2};
            load_pending <= is_read;
          end
          if ((bit_cnt == `VCATR_DATA_LAST_BIT) && !is_read) begin
            wr_data   <= {shift_in[6:0], sdi_s2};
            wr_strobe <= 1'b1;
          end
        end
        // read data is captured one cycle after the address settles
        if (load_pending) begin
          shift_out    <= rd_data;
          spi_sdo_oe_n <= 1'b0;
        end else if (sclk_fall && !spi_sdo_oe_n) begin
          spi_sdo   <= shift_out[7];
          shift_out <= {shift_out[6:0], 1'b0};
        end
      end
    end
  end

endmodule // vcatr_spi

// *** rtl/vcatr_timer.v ***
// loadable down counter stepped by the divided reference tick.
// assumes load and tick come from logic on ref_clk.
`timescale 1ns/1ns
module vcatr_timer (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        load,
  input  wire [14:0] load_value,
  input  wire        tick,
  output wire        expired
);

  reg [14:0] count;

  // ------------------------------------------------------------------
  // counter
  // ------------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 15'h0000;
    end else if (load) begin
      count <= load_value;
    end else if (tick && (count != 15'h0000)) begin
      count <= count - 15'h0001;
    end
  end

  // a zero load expires at once, so an unprogrammed phase is skipped
  assign expired = (count == 15'h0000);

endmodule // vcatr_timer

// *** rtl/vcatr_top.v ***
// oscillator calibration timing and temperature converter control bank.
// assumes div_rclk_tick, cal_start and staged values are on ref_clk.
`timescale 1ns/1ns
`include "vcatr_defs.vh"

//Contract
// - each calibration decision lasts 16 times the decision divider in divided ticks
// - dac settle phase lasts the 15-bit split timeout in divided ticks
// - level control phase is bounded by its 15-bit split timeout
// - dac-timeout bit 7 double buffers manual core, band and bias selections
// - level-timeout bit 7 double buffers invert, bleed current and polarity
// - no conversion unless conversion enable bit 7 and converter enable bit 1
// - auto bit 0 starts a conversion at each calibration start too
// - with auto bit clear, only the start trigger write converts
// - mute register holds out2 mute in bits 5:3, out1 in 2:0
// - writing start register bit 0 begins one conversion
// - status flag reads 1 while a conversion runs
// - status flag reads 1 while a calibration runs
module vcatr_top (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        spi_sclk,
  input  wire        spi_csb_n,
  input  wire        spi_sdi,
  output wire        spi_sdo,
  output wire        spi_sdo_oe_n,
  input  wire        div_rclk_tick,
  input  wire        cal_start,
  input  wire [1:0]  staged_osc_core,
  input  wire [7:0]  staged_osc_band,
  input  wire [3:0]  staged_osc_bias,
  input  wire        staged_output_invert,
  input  wire [7:0]  staged_bleed_current,
  input  wire        staged_bleed_polarity,
  output reg  [1:0]  manual_osc_core,
  output reg  [7:0]  manual_osc_band,
  output reg  [3:0]  manual_osc_bias,
  output reg         output_invert,
  output reg  [7:0]  bleed_current,
  output reg         bleed_polarity,
  output reg         cal_in_progress,
  output reg         cal_phase_settle,
  output reg         cal_phase_decide,
  output reg         cal_phase_level,
  output reg         cal_decision_strobe,
  output reg         cal_done,
  output reg         converter_enabled,
  output reg         conv_clk_tick,
  output reg         conv_in_progress,
  output reg         conv_done,
  output reg  [2:0]  out1_mute_ctrl,
  output reg  [2:0]  out2_mute_ctrl
);

  localparam [3:0] ST_IDLE   = 4'h1;
  localparam [3:0] ST_SETTLE = 4'h2;
  localparam [3:0] ST_DECIDE = 4'h4;
  localparam [3:0] ST_LEVEL  = 4'h8;

  reg  [7:0]  cal_decision_time;
  reg  [7:0]  dac_settle_timeout_lo;
  reg  [7:0]  dac_settle_timeout_hi_dbuf;
  reg  [7:0]  level_ctrl_timeout_lo;
  reg  [7:0]  level_ctrl_timeout_hi_dbuf;
  reg  [7:0]  converter_clock_divider;
  reg  [7:0]  converter_control;
  reg  [7:0]  output_mute_control;
  reg  [3:0]  state;
  reg  [3:0]  next_state;
  reg         next_load;
  reg  [14:0] next_load_value;
  reg  [2:0]  decision_cnt;
  reg  [4:0]  conv_cnt;
  reg  [7:0]  rd_data;
  wire [14:0] reg_addr;
  wire [7:0]  wr_data;
  wire        wr_strobe;
  wire        cal_expired;
  wire        div_expired;
  wire        cal_accept;
  wire        conv_allowed;
  wire        conv_request;
  wire        manual_osc_sel_dbuf;
  wire        delay_ctrl_dbuf;
  wire        auto_conv_on_cal;
  wire        conv_start_trigger;
  wire [14:0] dac_settle_timeout;
  wire [14:0] level_ctrl_timeout;
  wire [14:0] cal_decision_divider;
  wire [14:0] conv_div_value;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function [14:0] join_timeout;
    input [7:0] hi;
    input [7:0] lo;
    join_timeout = {hi[6:0], lo};
  endfunction

  function hit;
    input [14:0] addr;
    input [14:0] ofs;
    hit = (addr == ofs);
  endfunction

  // ------------------------------------------------------------------
  // serial port
  // ------------------------------------------------------------------
  vcatr_spi u_spi (
    .ref_clk      (ref_clk),
    .rst_n        (rst_n),
    .spi_sclk     (spi_sclk),
    .spi_csb_n    (spi_csb_n),
    .spi_sdi      (spi_sdi),
    .spi_sdo      (spi_sdo),
    .spi_sdo_oe_n (spi_sdo_oe_n),
    .rd_data      (rd_data),
    .reg_addr     (reg_addr),
    .wr_data      (wr_data),
    .wr_strobe    (wr_strobe)
  );

  // ------------------------------------------------------------------
  // register file
  // ------------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_decision_time          <= `VCATR_RST_REG;
      dac_settle_timeout_lo      <= `VCATR_RST_REG;
      dac_settle_timeout_hi_dbuf <= `VCATR_RST_REG;
      level_ctrl_timeout_lo      <= `VCATR_RST_REG;
      level_ctrl_timeout_hi_dbuf <= `VCATR_RST_REG;
      converter_clock_divider    <= `VCATR_RST_REG;
      converter_control          <= `VCATR_RST_REG;
      output_mute_control        <= `VCATR_RST_REG;
    end else if (wr_strobe) begin
      if (hit(reg_addr, `VCATR_OFS_DECISION))  cal_decision_time          <= wr_data;
      if (hit(reg_addr, `VCATR_OFS_DAC_LO))    dac_settle_timeout_lo      <= wr_data;
      if (hit(reg_addr, `VCATR_OFS_DAC_HI))    dac_settle_timeout_hi_dbuf <= wr_data;
      if (hit(reg_addr, `VCATR_OFS_LVL_LO))    level_ctrl_timeout_lo      <= wr_data;
      if (hit(reg_addr, `VCATR_OFS_LVL_HI))    level_ctrl_timeout_hi_dbuf <= wr_data;
      if (hit(reg_addr, `VCATR_OFS_CONV_DIV))  converter_clock_divider    <= wr_data;
      if (hit(reg_addr, `VCATR_OFS_CONV_CTRL)) converter_control          <= wr_data;
      if (hit(reg_addr, `VCATR_OFS_MUTE))      output_mute_control        <= wr_data;
    end
  end

  // read mux; the start trigger reads back zero and unmapped reads zero
  always @* begin
    rd_data = 8'h00;
    if (hit(reg_addr, `VCATR_OFS_DECISION))  rd_data = cal_decision_time;
    if (hit(reg_addr, `VCATR_OFS_DAC_LO))    rd_data = dac_settle_timeout_lo;
    if (hit(reg_addr, `VCATR_OFS_DAC_HI))    rd_data = dac_settle_timeout_hi_dbuf;
    if (hit(reg_addr, `VCATR_OFS_LVL_LO))    rd_data = level_ctrl_timeout_lo;
    if (hit(reg_addr, `VCATR_OFS_LVL_HI))    rd_data = level_ctrl_timeout_hi_dbuf;
    if (hit(reg_addr, `VCATR_OFS_CONV_DIV))  rd_data = converter_clock_divider;
    if (hit(reg_addr, `VCATR_OFS_CONV_CTRL)) rd_data = converter_control;
    if (hit(reg_addr, `VCATR_OFS_MUTE))      rd_data = output_mute_control;
    if (hit(reg_addr, `VCATR_OFS_STATUS)) begin
      rd_data[`VCATR_ST_CONV_BIT] = conv_in_progress;
      rd_data[`VCATR_ST_CAL_BIT]  = cal_in_progress;
    end
  end

  assign manual_osc_sel_dbuf  = dac_settle_timeout_hi_dbuf[`VCATR_DBUF_BIT];
  assign delay_ctrl_dbuf      = level_ctrl_timeout_hi_dbuf[`VCATR_DBUF_BIT];
  assign auto_conv_on_cal     = converter_control[`VCATR_AUTO_CONV_BIT];
  assign dac_settle_timeout   = join_timeout(dac_settle_timeout_hi_dbuf,
                                             dac_settle_timeout_lo);
  assign level_ctrl_timeout   = join_timeout(level_ctrl_timeout_hi_dbuf,
                                             level_ctrl_timeout_lo);
  assign cal_decision_divider = {3'h0, cal_decision_time, 4'h0};
  assign conv_div_value       = {5'h00, converter_clock_divider, 2'h0}
                                + `VCATR_CONV_DIV_ADD;
  assign conv_start_trigger   = wr_strobe && hit(reg_addr, `VCATR_OFS_CONV_START)
                                && wr_data[`VCATR_START_BIT];

  // ------------------------------------------------------------------
  // calibration sequencer
  // ------------------------------------------------------------------
  assign cal_accept = cal_start && (state == ST_IDLE);

  vcatr_timer u_cal_timer (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .load       (next_load),
    .load_value (next_load_value),
    .tick       (div_rclk_tick),
    .expired    (cal_expired)
  );

  always @* begin
    next_state      = state;
    next_load       = 1'b0;
    next_load_value = 15'h0000;
    case (state)
      ST_IDLE: begin
        if (cal_start) begin
          next_state      = ST_SETTLE;
          next_load       = 1'b1;
          next_load_value = dac_settle_timeout;
        end
      end
      ST_SETTLE: begin
        if (cal_expired) begin
          next_state      = ST_DECIDE;
          next_load       = 1'b1;
          next_load_value = cal_decision_divider;
        end
      end
      ST_DECIDE: begin
        if (cal_expired) begin
          next_load = 1'b1;
          if (decision_cnt == `VCATR_NUM_DECISIONS) begin
            next_state      = ST_LEVEL;
            next_load_value = level_ctrl_timeout;
          end else begin
            next_load_value = cal_decision_divider;
          end
        end
      end
      ST_LEVEL: begin
        if (cal_expired) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state               <= ST_IDLE;
      decision_cnt        <= 3'h0;
      cal_in_progress     <= 1'b0;
      cal_phase_settle    <= 1'b0;
      cal_phase_decide    <= 1'b0;
      cal_phase_level     <= 1'b0;
      cal_decision_strobe <= 1'b0;
      cal_done            <= 1'b0;
    end else begin
      state               <= next_state;
      cal_in_progress     <= (next_state != ST_IDLE);
      cal_phase_settle    <= (next_state == ST_SETTLE);
      cal_phase_decide    <= (next_state == ST_DECIDE);
      cal_phase_level     <= (next_state == ST_LEVEL);
      cal_decision_strobe <= (state == ST_DECIDE) && cal_expired;
      cal_done            <= (state == ST_LEVEL) && cal_expired;
      if (state != ST_DECIDE)
        decision_cnt <= 3'h0;
      else if (cal_expired)
        decision_cnt <= decision_cnt + 3'h1;
    end
  end

  // ------------------------------------------------------------------
  // double-buffered controls
  // ------------------------------------------------------------------
  // with bit 7 set, copies move only at calibration start, so no half-written update reaches the oscillator; with it clear they follow every cycle
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      manual_osc_core <= 2'h0;
      manual_osc_band <= 8'h00;
      manual_osc_bias <= 4'h0;
      output_invert   <= 1'b0;
      bleed_current   <= 8'h00;
      bleed_polarity  <= 1'b0;
    end else begin
      if (!manual_osc_sel_dbuf || cal_accept) begin
        manual_osc_core <= staged_osc_core;
        manual_osc_band <= staged_osc_band;
        manual_osc_bias <= staged_osc_bias;
      end
      if (!delay_ctrl_dbuf || cal_accept) begin
        output_invert  <= staged_output_invert;
        bleed_current  <= staged_bleed_current;
        bleed_polarity <= staged_bleed_polarity;
      end
    end
  end

  // ------------------------------------------------------------------
  // converter clock and conversion control
  // ------------------------------------------------------------------
  assign conv_allowed = converter_control[`VCATR_CONV_EN_BIT]
                        && converter_control[`VCATR_CONV_PWR_BIT];
  assign conv_request = conv_start_trigger || (cal_accept && auto_conv_on_cal);

  vcatr_timer u_conv_div (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .load       (!converter_enabled || div_expired),
    .load_value (conv_div_value),
    .tick       (div_rclk_tick),
    .expired    (div_expired)
  );

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      converter_enabled <= 1'b0;
      conv_clk_tick     <= 1'b0;
      conv_in_progress  <= 1'b0;
      conv_done         <= 1'b0;
      conv_cnt          <= 5'h00;
      out1_mute_ctrl    <= 3'h0;
      out2_mute_ctrl    <= 3'h0;
    end else begin
      converter_enabled <= converter_control[`VCATR_CONV_PWR_BIT];
      conv_clk_tick     <= converter_enabled && div_expired;
      conv_done         <= 1'b0;
      out1_mute_ctrl    <= output_mute_control[`VCATR_MUTE1_HI:`VCATR_MUTE1_LO];
      out2_mute_ctrl    <= output_mute_control[`VCATR_MUTE2_HI:`VCATR_MUTE2_LO];
      if (!conv_allowed) begin
        // clearing an enable aborts a running conversion without done
        conv_in_progress <= 1'b0;
        conv_cnt         <= 5'h00;
      end else if (!conv_in_progress) begin
        if (conv_request) begin
          conv_in_progress <= 1'b1;
          conv_cnt         <= 5'h00;
        end
      end else if (conv_clk_tick) begin
        if (conv_cnt == (`VCATR_CONV_CYCLES - 5'h01)) begin
          conv_in_progress <= 1'b0;
          conv_done        <= 1'b1;
        end else begin
          conv_cnt <= conv_cnt + 5'h01;
        end
      end
    end
  end

endmodule // vcatr_top

// *** verif/testbench.sv ***
// self-checking bench for the calibration and converter timing bank
// assumes rtl/ on the include path; the bench drives the serial pins
`timescale 1ns/1ns
`include "vcatr_defs.vh"
module testbench;
  logic        ref_clk = 0;
  logic        rst_n = 0;
  logic        spi_sclk = 0;
  logic        spi_csb_n = 1;
  logic        spi_sdi = 0;
  logic        div_rclk_tick = 0;
  logic        cal_start = 0;
  logic [23:0] stg = 0;
  wire         spi_sdo, spi_sdo_oe_n;
  wire  [1:0]  staged_osc_core = stg[23:22];
  wire  [7:0]  staged_osc_band = stg[21:14];
  wire  [3:0]  staged_osc_bias = stg[13:10];
  wire         staged_output_invert = stg[9];
  wire  [7:0]  staged_bleed_current = stg[8:1];
  wire         staged_bleed_polarity = stg[0];
  wire  [1:0]  manual_osc_core;
  wire  [7:0]  manual_osc_band, bleed_current;
  wire  [3:0]  manual_osc_bias;
  wire         output_invert, bleed_polarity, cal_in_progress, cal_phase_settle;
  wire         cal_phase_decide, cal_phase_level, cal_decision_strobe, cal_done;
  wire         converter_enabled, conv_clk_tick, conv_in_progress, conv_done;
  wire  [2:0]  out1_mute_ctrl, out2_mute_ctrl;
  wire  [23:0] act = {manual_osc_core, manual_osc_band, manual_osc_bias,
                      output_invert, bleed_current, bleed_polarity};
  // cnt: settle, decide, level ticks, strobes, conv clocks, conv done
  int          cyc, mismatches, num_checks, cnt [6];
  logic [7:0]  q, d, d40;
  logic [14:0] adr [12] = '{15'h0037, 15'h0038, 15'h0039, 15'h003A, 15'h003B, 15'h003C,
                            15'h003E, 15'h003F, 15'h0040, 15'h0041, 15'h0054, 15'h0058};
  logic [7:0]  cv [3] = '{8'h02, 8'h80, 8'h83};

  vcatr_top dut (.*);

  always #25 ref_clk = ~ref_clk;

  // ticks every third cycle, never back to back, so no tick is lost at a reload
  always @(posedge ref_clk) begin
    cyc++;
    div_rclk_tick <= #1 (cyc % 3 == 0);
    if (div_rclk_tick && cal_phase_settle) cnt[0]++;
    if (div_rclk_tick && cal_phase_decide) cnt[1]++;
    if (div_rclk_tick && cal_phase_level) cnt[2]++;
    if (cal_decision_strobe) cnt[3]++;
    if (conv_clk_tick && conv_in_progress) cnt[4]++;
    if (conv_done) cnt[5]++;
    if (cyc == 60000) begin
      mismatches++;
      complete_run();
    end
  end

  // ----------
  // tasks
  // ----------
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // half period of six cycles leaves room for the pin synchronisers
  task automatic spi(input logic r, input logic [14:0] a, input logic [7:0] w);
    logic [23:0] f;
    f = {r, a, w};
    spi_csb_n = 0;
    for (int i = 23; i >= 0; i--) begin
      spi_sdi = f[i];
      step(6);
      if (i < 8) q[i] = spi_sdo;
      if (i == 0) check("sdo enable", spi_sdo_oe_n, !r);
      spi_sclk = 1;
      step(6);
      spi_sclk = 0;
    end
    step(6);
    spi_csb_n = 1;
    step(6);
    check("sdo release", spi_sdo_oe_n, 1'b1);
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] w);
    spi(1'b0, a, w);
  endtask

  function automatic logic [7:0] rb(input logic [14:0] a, input logic [7:0] w);
    rb = (a inside {[15'h0037:15'h003B], [15'h003E:15'h0040]}) ? w : 8'h00;
  endfunction

  task automatic run_cal(input logic dbuf, input logic [7:0] ctrl);
    logic [7:0]  dv;
    logic [14:0] ts, tl;
    logic [23:0] old;
    dv = 8'(1 + $urandom % 2);
    ts = 15'(100 + $urandom % 50);
    tl = 15'(1 + $urandom % 20);
    wr(15'h0037, dv);
    wr(15'h0038, ts[7:0]);
    wr(15'h0039, {dbuf, ts[14:8]});
    wr(15'h003A, tl[7:0]);
    wr(15'h003B, {dbuf, tl[14:8]});
    wr(15'h003E, 8'h04);
    wr(15'h003F, ctrl);
    old = act;
    stg = $urandom;
    step(2);
    check("osc sel", act[23:10], dbuf ? old[23:10] : stg[23:10]);
    check("delay ctl", act[9:0], dbuf ? old[9:0] : stg[9:0]);
    cnt = '{default: 0};
    cal_start = 1;
    step(1);
    cal_start = 0;
    check("cal busy", cal_in_progress, 1'b1);
    check("dbuf copy", act, stg);
    check("auto conv", conv_in_progress, ctrl[0]);
    spi(1'b1, `VCATR_OFS_STATUS, 8'h00);
    check("status cal", q, {5'h00, ctrl[0], 2'b10});
    for (int k = 0; k < 3000 && cal_done !== 1'b1; k++) step(1);
    for (int k = 0; k < 1200 && conv_in_progress === 1'b1; k++) step(1);
    check("settle ticks", cnt[0], ts);
    check("decide ticks", cnt[1], 128 * dv);
    check("decisions", cnt[3], 8);
    check("level ticks", cnt[2], tl);
    check("auto clocks", cnt[4], ctrl[0] ? 16 : 0);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------
  // sequence
  // ----------
  initial begin
    void'($urandom(32'hB95D6C29));
    step(20);
    rst_n = 1;
    step(3);
    foreach (adr[i]) begin
      d = $urandom;
      if (adr[i] == 15'h0054) d[0] = 1'b0;
      if (adr[i] == 15'h003E) d[7] = 1'b1;
      spi(1'b1, adr[i], 8'h00);
      check("reset value", q, 8'h00);
      wr(adr[i], d);
      spi(1'b1, adr[i], 8'h00);
      check("readback", q, rb(adr[i], d));
      if (adr[i] == 15'h0040) d40 = d;
    end
    check("out1 mute", out1_mute_ctrl, d40[2:0]);
    check("out2 mute", out2_mute_ctrl, d40[5:3]);
    run_cal(1'b0, 8'h82);
    run_cal(1'b1, 8'h83);
    foreach (cv[i]) begin
      wr(15'h003F, cv[i]);
      cnt = '{default: 0};
      wr(`VCATR_OFS_CONV_START, 8'h01);
      step(1000);
      check("conv runs", cnt[5], cv[i][7] & cv[i][1]);
      check("conv clocks", cnt[4], (cv[i][7] & cv[i][1]) ? 16 : 0);
    end
    // slow converter clock keeps the conversion busy across two frames
    wr(15'h003E, 8'h14);
    cnt = '{default: 0};
    wr(`VCATR_OFS_CONV_START, 8'h01);
    spi(1'b1, `VCATR_OFS_STATUS, 8'h00);
    check("status conv", q, 8'h04);
    wr(`VCATR_OFS_CONV_START, 8'h01);
    for (int k = 0; k < 6000 && cnt[5] == 0; k++) step(1);
    step(300);
    check("one conv", cnt[5], 1);
    complete_run();
  end
endmodule // testbench

// *** verif/vcatr_monitor.sv ***
// port assertions for the calibration and converter bank
// assumes a single ref_clk domain and binding to vcatr_top
`timescale 1ns/1ns
module vcatr_monitor (
  input wire ref_clk,
  input wire rst_n,
  input wire cal_start,
  input wire cal_in_progress,
  input wire cal_phase_settle,
  input wire cal_phase_decide,
  input wire cal_phase_level,
  input wire cal_decision_strobe,
  input wire cal_done,
  input wire converter_enabled,
  input wire conv_clk_tick,
  input wire conv_in_progress,
  input wire conv_done
);
  // ----------
  // checks
  // ----------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  cal_start_taken_a: assert property (
    cal_start && !cal_in_progress && !cal_done |=> cal_in_progress && cal_phase_settle)
    else $error("calibration start not taken");
  phase_onehot_a: assert property (
    $onehot0({cal_phase_settle, cal_phase_decide, cal_phase_level}) &&
    (cal_in_progress || !(cal_phase_settle | cal_phase_decide | cal_phase_level)))
    else $error("calibration phases inconsistent");
  decide_follows_a: assert property (
    $rose(cal_phase_decide) |-> $past(cal_phase_settle)) else $error("decide without settle");
  strobe_in_decide_a: assert property (
    cal_decision_strobe |-> $past(cal_phase_decide)) else $error("strobe outside decide");
  cal_done_end_a: assert property (
    cal_done |-> !cal_in_progress && $past(cal_phase_level) ##1 !cal_done)
    else $error("calibration end wrong");
  conv_gate_a: assert property (
    $rose(conv_in_progress) |-> converter_enabled) else $error("conversion while disabled");
  conv_tick_gate_a: assert property (
    conv_clk_tick |-> $past(converter_enabled)) else $error("converter clock while off");
  conv_done_end_a: assert property (
    conv_done |-> !conv_in_progress && $past(conv_in_progress)) else $error("bad conversion end");
  cal_seen_c: cover property (cal_done);
  conv_seen_c: cover property (conv_done);
  strobe_seen_c: cover property (cal_decision_strobe);
endmodule // vcatr_monitor

bind vcatr_top vcatr_monitor u_monitor (.*);
